// ==== include/mac_pkg.sv ====
package mac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and counts.
  localparam int ADDR_W        = 20;
  localparam int BANK_W        = 4;
  localparam int BANKS         = 16;
  localparam int MODE_W        = 18;
  localparam int TIMER_W       = 8;
  localparam int MAX_MULTIBANK = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Commands on the pins and capture states.
  typedef enum logic [2:0] {
    MAC_NOP,
    MAC_READ,
    MAC_WRITE,
    MAC_REFRESH,
    MAC_MODESET
  } mac_cmd_t;

  typedef enum logic {
    MAC_ST_FIRST,
    MAC_ST_SECOND
  } mac_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register fields.
  localparam int MODE0_MUX_BIT     = 9;
  localparam int MODE1_REFRESH_BIT = 8;
  localparam int MODE1_BL_LSB      = 3;
  localparam int MODE1_ODT_LSB     = 1;
  localparam logic [1:0] BL_TWO   = 2'h0;
  localparam logic [1:0] BL_FOUR  = 2'h1;
  localparam logic [1:0] BL_EIGHT = 2'h2;
  localparam logic [1:0] MR_SEL_ZERO = 2'h0;
  localparam logic [1:0] MR_SEL_ONE  = 2'h1;
  localparam logic [1:0] MR_SEL_TWO  = 2'h2;
  localparam logic [MODE_W-1:0] MR_RESET = 18'h0_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Row cycle time, rounded up to whole 20 ns cycles.
  localparam int ROW_CYCLE_NS = 10;
  localparam int CLK_MHZ      = 50;
  localparam int TRC_CYC_INT  = (ROW_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [TIMER_W-1:0] TRC_RESET =
    (TRC_CYC_INT < 1) ? 8'h01 : TIMER_W'(TRC_CYC_INT);

  ////////////////////////////////////////////////////////////////////////////
  // APB register map.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MODE0_OFS  = 8'h08;
  localparam logic [7:0] MODE1_OFS  = 8'h0c;
  localparam logic [7:0] MODE2_OFS  = 8'h10;
  localparam logic [7:0] TRC_OFS    = 8'h14;
  localparam logic [7:0] ERR_OFS    = 8'h18;
  localparam int CTRL_WIDE_BIT      = 0;
  localparam int ST_MUX_BIT         = 0;
  localparam int ST_INIT_BIT        = 1;
  localparam int ST_ODT_BIT         = 2;
  localparam int ST_PEND_BIT        = 3;
  localparam int ERR_CONFLICT_BIT   = 0;
  localparam int ERR_MANYBANK_BIT   = 1;

endpackage

// ==== rtl/mac_addr_merge.sv ====
`timescale 1ns/1ps
module mac_addr_merge (
  // Two captured address parts.
  input  wire logic [19:0] first_part,
  input  wire logic [19:0] second_part,
  // Configuration.
  input  wire logic        wide_x36,
  input  wire logic [1:0]  burst_code,
  // Merged internal address.
  output logic      [19:0] full_addr
);

  logic longest;

  always_comb begin
    longest   = wide_x36 ? (burst_code == mac_pkg::BL_FOUR)
                         : (burst_code == mac_pkg::BL_EIGHT);
    full_addr = '0;
    full_addr[0]  = first_part[0];
    full_addr[3]  = first_part[3];
    full_addr[4]  = first_part[4];
    full_addr[5]  = first_part[5];
    full_addr[8]  = first_part[8];
    full_addr[9]  = first_part[9];
    full_addr[10] = first_part[10];
    full_addr[13] = first_part[13];
    full_addr[14] = first_part[14];
    full_addr[17] = first_part[17];
    full_addr[18] = longest ? 1'b0 : first_part[18];
    full_addr[1]  = second_part[3];
    full_addr[2]  = second_part[4];
    full_addr[6]  = second_part[8];
    full_addr[7]  = second_part[9];
    full_addr[11] = second_part[13];
    full_addr[12] = second_part[14];
    full_addr[16] = second_part[17];
    full_addr[15] = second_part[18];
    if (!wide_x36 && burst_code == mac_pkg::BL_TWO) begin
      full_addr[19] = second_part[10];
    end
  end

endmodule

// ==== rtl/mac_bank_timer.sv ====
`timescale 1ns/1ps
module mac_bank_timer (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Start of a row cycle.
  input  wire logic       load,
  input  wire logic [7:0] load_value,
  // Bank still inside its row cycle.
  output logic            busy
);

  logic [7:0] count_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= 8'h00;
    end else if (load) begin
      count_reg <= load_value;
    end else if (count_reg != 8'h00) begin
      count_reg <= count_reg - 8'h01;
    end
  end

  assign busy = (count_reg != 8'h00);

endmodule

// ==== rtl/mac_capture.sv ====
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module mac_capture (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // APB slave.
  input  wire logic [7:0]                paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Command and address pins.
  input  wire logic                      cs_n,
  input  wire logic                      we_n,
  input  wire logic                      ref_n,
  input  wire logic [19:0]               addr_pins,
  input  wire logic [3:0]                bank_pins,
  // Executed command.
  output logic                           exec_valid,
  output mac_pkg::mac_cmd_t              exec_cmd,
  output logic      [19:0]               exec_addr,
  output logic      [3:0]                exec_bank,
  output logic      [15:0]               refresh_mask,
  output logic                           latency_start,
  output logic                           row_cycle_start,
  // Mode status.
  output logic                           mux_mode,
  output logic                           odt_enable,
  output logic      [1:0]                odt_value
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  mac_pkg::mac_state_t             state_reg;
  mac_pkg::mac_cmd_t               pend_cmd_reg;
  logic [19:0]                     pend_addr_reg;
  logic [3:0]                      pend_bank_reg;
  logic                            pend_skip_reg;
  logic [mac_pkg::MODE_W-1:0]      mode0_reg;
  logic [mac_pkg::MODE_W-1:0]      mode1_reg;
  logic [mac_pkg::MODE_W-1:0]      mode2_reg;
  logic                            init_done_reg;
  logic                            wide_reg;
  logic [7:0]                      trc_reg;
  logic [1:0]                      err_reg;
  logic [31:0]                     prdata_reg;
  logic                            pready_reg;
  logic                            pslverr_reg;
  logic                            exec_valid_reg;
  mac_pkg::mac_cmd_t               exec_cmd_reg;
  logic [19:0]                     exec_addr_reg;
  logic [3:0]                      exec_bank_reg;
  logic [15:0]                     refresh_mask_reg;
  logic                            latency_start_reg;
  logic                            row_cycle_start_reg;
  logic                            odt_enable_reg;
  logic [1:0]                      odt_value_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode and execution select.
  mac_pkg::mac_cmd_t pin_cmd;
  logic              mux_now;
  logic              multibank;
  logic              take_new;
  logic              new_valid;
  logic              exec_now;
  mac_pkg::mac_cmd_t exec_cmd_c;
  logic [19:0]       exec_addr_c;
  logic [3:0]        exec_bank_c;
  logic [19:0]       merged_addr;
  logic [15:0]       target_mask;
  logic              too_many;
  logic [15:0]       busy_vec;
  logic              load_ok;
  logic [7:0]        trc_load;

  always_comb begin
    case ({cs_n, ref_n, we_n})
      3'b000:  pin_cmd = mac_pkg::MAC_MODESET;
      3'b011:  pin_cmd = mac_pkg::MAC_READ;
      3'b010:  pin_cmd = mac_pkg::MAC_WRITE;
      3'b001:  pin_cmd = mac_pkg::MAC_REFRESH;
      default: pin_cmd = mac_pkg::MAC_NOP;
    endcase
  end

  assign mux_now   = mode0_reg[mac_pkg::MODE0_MUX_BIT];
  assign multibank = mode1_reg[mac_pkg::MODE1_REFRESH_BIT];

  // A bank-selected refresh leaves the next edge free for a new command.
  assign take_new  = (state_reg == mac_pkg::MAC_ST_FIRST) || pend_skip_reg;
  assign new_valid = take_new && (pin_cmd != mac_pkg::MAC_NOP);

  mac_addr_merge u_merge (
    .first_part  (pend_addr_reg),
    .second_part (addr_pins),
    .wide_x36    (wide_reg),
    .burst_code  (mode1_reg[mac_pkg::MODE1_BL_LSB +: 2]),
    .full_addr   (merged_addr)
  );

  always_comb begin
    exec_now    = 1'b0;
    exec_cmd_c  = mac_pkg::MAC_NOP;
    exec_addr_c = '0;
    exec_bank_c = '0;
    if (state_reg == mac_pkg::MAC_ST_SECOND) begin
      exec_now    = 1'b1;
      exec_cmd_c  = pend_cmd_reg;
      exec_addr_c = merged_addr;
      exec_bank_c = pend_bank_reg;
    end else if (!mux_now && new_valid) begin
      exec_now    = 1'b1;
      exec_cmd_c  = pin_cmd;
      exec_addr_c = addr_pins;
      exec_bank_c = bank_pins;
    end
  end

  // Refresh targets come from one ball set only, by protocol.
  always_comb begin
    target_mask = 16'h0000;
    if (exec_cmd_c == mac_pkg::MAC_REFRESH && multibank) begin
      target_mask = exec_addr_c[15:0];
    end else if (exec_cmd_c != mac_pkg::MAC_MODESET && exec_cmd_c != mac_pkg::MAC_NOP) begin
      target_mask = 16'h0001 << exec_bank_c;
    end
  end

  assign too_many = ($countones(target_mask) > mac_pkg::MAX_MULTIBANK);
  assign load_ok  = exec_now && !too_many;

  // The first-part edge was one cycle earlier in two-part mode.
  assign trc_load = (state_reg == mac_pkg::MAC_ST_SECOND && trc_reg > 8'h01)
                    ? trc_reg - 8'h01 : trc_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Per-bank row cycle timers.
  genvar gi;
  generate
    for (gi = 0; gi < mac_pkg::BANKS; gi = gi + 1) begin : g_bank
      mac_bank_timer u_timer (
        .clk        (clk),
        .rst_n      (rst_n),
        .load       (load_ok && target_mask[gi]),
        .load_value (trc_load),
        .busy       (busy_vec[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Two-part capture.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg     <= mac_pkg::MAC_ST_FIRST;
      pend_cmd_reg  <= mac_pkg::MAC_NOP;
      pend_addr_reg <= '0;
      pend_bank_reg <= '0;
      pend_skip_reg <= 1'b0;
    end else if (mux_now && new_valid) begin
      state_reg     <= mac_pkg::MAC_ST_SECOND;
      pend_cmd_reg  <= pin_cmd;
      pend_addr_reg <= addr_pins;
      pend_bank_reg <= bank_pins;
      pend_skip_reg <= (pin_cmd == mac_pkg::MAC_REFRESH) && !multibank;
    end else begin
      state_reg     <= mac_pkg::MAC_ST_FIRST;
      pend_skip_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode0_reg     <= mac_pkg::MR_RESET;
      mode1_reg     <= mac_pkg::MR_RESET;
      mode2_reg     <= mac_pkg::MR_RESET;
      init_done_reg <= 1'b0;
    end else if (exec_now && exec_cmd_c == mac_pkg::MAC_MODESET) begin
      case (exec_bank_c[1:0])
        mac_pkg::MR_SEL_ZERO: mode0_reg <= exec_addr_c[mac_pkg::MODE_W-1:0];
        mac_pkg::MR_SEL_ONE:  mode1_reg <= exec_addr_c[mac_pkg::MODE_W-1:0];
        mac_pkg::MR_SEL_TWO: begin
          mode2_reg     <= exec_addr_c[mac_pkg::MODE_W-1:0];
          init_done_reg <= 1'b1;
        end
        default: mode2_reg <= mode2_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution outputs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exec_valid_reg      <= 1'b0;
      exec_cmd_reg        <= mac_pkg::MAC_NOP;
      exec_addr_reg       <= '0;
      exec_bank_reg       <= '0;
      refresh_mask_reg    <= '0;
      latency_start_reg   <= 1'b0;
      row_cycle_start_reg <= 1'b0;
    end else begin
      exec_valid_reg      <= load_ok;
      exec_cmd_reg        <= exec_cmd_c;
      exec_addr_reg       <= exec_addr_c;
      exec_bank_reg       <= exec_bank_c;
      refresh_mask_reg    <= (exec_cmd_c == mac_pkg::MAC_REFRESH && load_ok) ? target_mask
                                                                             : 16'h0000;
      latency_start_reg   <= exec_now && (exec_cmd_c == mac_pkg::MAC_READ ||
                                          exec_cmd_c == mac_pkg::MAC_WRITE);
      row_cycle_start_reg <= new_valid && (pin_cmd != mac_pkg::MAC_MODESET);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      odt_enable_reg <= 1'b0;
      odt_value_reg  <= 2'h0;
    end else begin
      odt_value_reg  <= mode1_reg[mac_pkg::MODE1_ODT_LSB +: 2];
      odt_enable_reg <= init_done_reg && (mode1_reg[mac_pkg::MODE1_ODT_LSB +: 2] != 2'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: registered answer, one access cycle, no wait states.
  logic        wr_en;
  logic [31:0] rd_value;
  logic        rd_hit;
  logic [1:0]  err_set;

  assign wr_en = psel && penable && pready_reg && pwrite;

  always_comb begin
    rd_hit   = 1'b1;
    rd_value = 32'h0000_0000;
    case (paddr)
      mac_pkg::CTRL_OFS:   rd_value[mac_pkg::CTRL_WIDE_BIT] = wide_reg;
      mac_pkg::STATUS_OFS: begin
        rd_value[mac_pkg::ST_MUX_BIT]  = mux_now;
        rd_value[mac_pkg::ST_INIT_BIT] = init_done_reg;
        rd_value[mac_pkg::ST_ODT_BIT]  = odt_enable_reg;
        rd_value[mac_pkg::ST_PEND_BIT] = (state_reg == mac_pkg::MAC_ST_SECOND);
      end
      mac_pkg::MODE0_OFS:  rd_value[mac_pkg::MODE_W-1:0] = mode0_reg;
      mac_pkg::MODE1_OFS:  rd_value[mac_pkg::MODE_W-1:0] = mode1_reg;
      mac_pkg::MODE2_OFS:  rd_value[mac_pkg::MODE_W-1:0] = mode2_reg;
      mac_pkg::TRC_OFS:    rd_value[7:0] = trc_reg;
      mac_pkg::ERR_OFS:    rd_value[1:0] = err_reg;
      default:             rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= psel && !penable;
      pslverr_reg <= psel && !penable && !rd_hit;
      prdata_reg  <= (psel && !penable && !pwrite) ? rd_value : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wide_reg <= 1'b0;
      trc_reg  <= mac_pkg::TRC_RESET;
    end else if (wr_en && paddr == mac_pkg::CTRL_OFS) begin
      wide_reg <= pwdata[mac_pkg::CTRL_WIDE_BIT];
    end else if (wr_en && paddr == mac_pkg::TRC_OFS) begin
      // Zero would disable the conflict check altogether, so it is held at one.
      trc_reg  <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
    end
  end

  // A new event in the clearing cycle survives the clear.
  assign err_set[mac_pkg::ERR_CONFLICT_BIT] = exec_now && |(busy_vec & target_mask);
  assign err_set[mac_pkg::ERR_MANYBANK_BIT] = exec_now && too_many;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_reg <= 2'h0;
    end else if (wr_en && paddr == mac_pkg::ERR_OFS) begin
      err_reg <= (err_reg & ~pwdata[1:0]) | err_set;
    end else begin
      err_reg <= err_reg | err_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign exec_valid      = exec_valid_reg;
  assign exec_cmd        = exec_cmd_reg;
  assign exec_addr       = exec_addr_reg;
  assign exec_bank       = exec_bank_reg;
  assign refresh_mask    = refresh_mask_reg;
  assign latency_start   = latency_start_reg;
  assign row_cycle_start = row_cycle_start_reg;
  assign mux_mode        = mode0_reg[mac_pkg::MODE0_MUX_BIT];
  assign odt_enable      = odt_enable_reg;
  assign odt_value       = odt_value_reg;

endmodule

// ==== bench/mac_capture_monitor.sv ====
`timescale 1ns/1ps
module mac_capture_monitor (
  // Clock and reset.
  input wire logic               clk,
  input wire logic               rst_n,
  // Command pins.
  input wire logic               cs_n,
  input wire logic               we_n,
  input wire logic               ref_n,
  // Executed command and mode status.
  input wire logic               exec_valid,
  input wire mac_pkg::mac_cmd_t  exec_cmd,
  input wire logic [19:0]        exec_addr,
  input wire logic [3:0]         exec_bank,
  input wire logic [15:0]        refresh_mask,
  input wire logic               latency_start,
  input wire logic               row_cycle_start,
  input wire logic               mux_mode,
  input wire logic               odt_enable,
  input wire logic [1:0]         odt_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_exec_single: assert property (
    !mux_mode && {cs_n, ref_n, we_n} == 3'b011
    |=> exec_valid && exec_cmd == mac_pkg::MAC_READ && latency_start)
    else $error("single-cycle read not executed one edge later");
  a_exec_mux: assert property (
    mux_mode && row_cycle_start |=> exec_valid)
    else $error("two-part command not executed on the following edge");
  a_latency_mux: assert property (
    mux_mode && latency_start |-> $past(row_cycle_start))
    else $error("latency reference not one edge after the first part");
  a_latency_rw: assert property (
    latency_start |-> exec_valid && exec_cmd inside {mac_pkg::MAC_READ, mac_pkg::MAC_WRITE})
    else $error("latency reference without a read or write");
  a_row_single: assert property (
    !mux_mode && exec_valid && exec_cmd inside {mac_pkg::MAC_READ, mac_pkg::MAC_WRITE,
      mac_pkg::MAC_REFRESH} |-> row_cycle_start)
    else $error("row cycle not started with a single-cycle command");
  a_mask_only: assert property (
    refresh_mask != 16'h0000 |-> exec_valid && exec_cmd == mac_pkg::MAC_REFRESH)
    else $error("refresh mask outside an executed refresh");
  a_mask_four: assert property (
    exec_valid && exec_cmd == mac_pkg::MAC_REFRESH |-> $countones(refresh_mask) inside {[1:4]})
    else $error("refresh touches no bank or more than four");
  a_mux_entry: assert property (
    exec_valid && exec_cmd == mac_pkg::MAC_MODESET && exec_bank[1:0] == 2'h0 && exec_addr[9]
    |-> ##[0:1] mux_mode)
    else $error("two-part mode not entered after bit 9 written");
  a_odt_value: assert property (
    odt_enable |-> odt_value != 2'h0)
    else $error("termination enabled with no value");
endmodule

bind mac_capture mac_capture_monitor u_mon (
  .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .we_n(we_n), .ref_n(ref_n),
  .exec_valid(exec_valid), .exec_cmd(exec_cmd), .exec_addr(exec_addr),
  .exec_bank(exec_bank), .refresh_mask(refresh_mask), .latency_start(latency_start),
  .row_cycle_start(row_cycle_start), .mux_mode(mux_mode), .odt_enable(odt_enable),
  .odt_value(odt_value)
);

// ==== bench/mac_ctrl_model.sv ====
`timescale 1ns/1ps
module mac_ctrl_model (
  // Clock.
  input  wire logic        clk,
  // Command and address pins.
  output logic             cs_n,
  output logic             we_n,
  output logic             ref_n,
  output logic      [19:0] addr_pins,
  output logic      [3:0]  bank_pins
);
  initial begin
    {cs_n, ref_n, we_n} = 3'b111;
    addr_pins = 20'h0_0000;
    bank_pins = 4'h0;
  end

  // Entered and left just after a rising edge. Idle lines do not keep the last
  // value unless chain is set, so a design that samples them late sees garbage.
  task automatic issue(input logic [2:0] code, input logic [19:0] ax,
                       input logic [19:0] ay, input logic [3:0] bk,
                       input bit two, input bit chain);
    logic [3:0] b;
    b = (code == 3'b000) ? {2'b00, bk[1:0]} : bk;
    {cs_n, ref_n, we_n} <= code;
    addr_pins <= ax;
    bank_pins <= b;
    @(posedge clk);
    if (chain) return;
    {cs_n, ref_n, we_n} <= 3'b111;
    addr_pins <= two ? ay : ~ax;
    bank_pins <= two ? b : ~b;
    @(posedge clk);
    if (two) begin
      addr_pins <= ~ay;
      bank_pins <= ~b;
      @(posedge clk);
    end
  endtask
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  localparam logic [2:0]  RD = 3'b011;
  localparam logic [2:0]  WR = 3'b010;
  localparam logic [2:0]  RF = 3'b001;
  localparam logic [2:0]  MS = 3'b000;
  localparam logic [43:0] ALL = 44'hfff_ffff_ffff;
  localparam logic [43:0] CMD = 44'he00_0000_0001;
  localparam logic [43:0] REF = 44'he00_0001_ffff;
  localparam int          SPACING = 4;
  logic              clk;
  logic              rst_n;
  logic [7:0]        paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              cs_n;
  logic              we_n;
  logic              ref_n;
  logic [19:0]       addr_pins;
  logic [3:0]        bank_pins;
  logic              exec_valid;
  mac_pkg::mac_cmd_t exec_cmd;
  logic [19:0]       exec_addr;
  logic [3:0]        exec_bank;
  logic [15:0]       refresh_mask;
  logic              latency_start;
  logic              row_cycle_start;
  logic              mux_mode;
  logic              odt_enable;
  logic [1:0]        odt_value;
  int                failures;
  int                num_checks;
  logic [43:0]       seen[$];
  logic [87:0]       want[$];
  logic [31:0]       q;
  logic              e;
  logic [15:0]       m;
  logic              wide;
  logic [1:0]        bl;

  mac_capture uut (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cs_n(cs_n), .we_n(we_n), .ref_n(ref_n),
    .addr_pins(addr_pins), .bank_pins(bank_pins), .exec_valid(exec_valid),
    .exec_cmd(exec_cmd), .exec_addr(exec_addr), .exec_bank(exec_bank),
    .refresh_mask(refresh_mask), .latency_start(latency_start),
    .row_cycle_start(row_cycle_start), .mux_mode(mux_mode),
    .odt_enable(odt_enable), .odt_value(odt_value));
  mac_ctrl_model ctrl (
    .clk(clk), .cs_n(cs_n), .we_n(we_n), .ref_n(ref_n),
    .addr_pins(addr_pins), .bank_pins(bank_pins));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(negedge clk) begin
    if (exec_valid === 1'b1) begin
      seen.push_back({exec_cmd, exec_addr, exec_bank, refresh_mask, latency_start});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic compare(input logic [43:0] got, input logic [43:0] exp,
                         input logic [43:0] care);
    num_checks++;
    if (((got ^ exp) & care) !== 44'h0) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0000_0000);
    compare({11'h0, e, q}, {11'h0, err, exp}, ALL);
  endtask

  function automatic logic [19:0] merge(input logic [19:0] ax, input logic [19:0] ay,
                                        input logic w, input logic [1:0] b);
    logic [19:0] r;
    r = ax & 20'h2_6739;
    if (!(w ? b == mac_pkg::BL_FOUR : b == mac_pkg::BL_EIGHT)) r[18] = ax[18];
    {r[1], r[2], r[6], r[7]} = {ay[3], ay[4], ay[8], ay[9]};
    {r[11], r[12], r[16], r[15]} = {ay[13], ay[14], ay[17], ay[18]};
    if (!w && b == mac_pkg::BL_TWO) r[19] = ay[10];
    return r;
  endfunction

  task automatic want_exec(input mac_pkg::mac_cmd_t c, input logic [19:0] a,
                           input logic [3:0] b, input logic [15:0] mk,
                           input logic l, input logic [43:0] care);
    want.push_back({c, a, b, mk, l, care});
  endtask

  task automatic cmd_rw(input bit two, input logic w, input logic [1:0] b,
                        input logic [3:0] bk);
    logic [19:0] ax;
    logic [19:0] ay;
    bit          isw;
    ax = 20'($urandom);
    ay = 20'($urandom);
    isw = 1'($urandom);
    ctrl.issue(isw ? WR : RD, ax, ay, bk, two, 1'b0);
    want_exec(isw ? mac_pkg::MAC_WRITE : mac_pkg::MAC_READ,
              two ? merge(ax, ay, w, b) : ax, bk, 16'h0, 1'b1, ALL);
  endtask

  // In two-part mode the value is split so that merging gives it back.
  task automatic mode_register_set_cmd(input logic [1:0] sel, input logic [17:0] v, input bit two);
    logic [19:0] ay;
    ay = {1'b0, v[15], v[16], 2'b0, v[12], v[11], 3'b0, v[7], v[6], 3'b0, v[2], v[1], 3'b0};
    ctrl.issue(MS, two ? {2'b0, v} & 20'h2_6739 : {2'b0, v}, ay, {2'b0, sel}, two, 1'b0);
    want_exec(mac_pkg::MAC_MODESET, 20'h0, 4'h0, 16'h0, 1'b0, CMD);
  endtask

  task automatic end_test(input string s);
    logic [87:0] w;
    logic [43:0] got;
    while (want.size() > 0) begin
      w = want.pop_front();
      got = (seen.size() > 0) ? seen.pop_front() : 44'hx;
      compare(got, w[87:44], w[43:0]);
    end
    compare(44'(seen.size()), 44'h0, ALL);
    seen.delete();
    $display("test %s finished", s);
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    num_checks = 0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    m = 16'($urandom(32'h6fd4));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(mac_pkg::TRC_OFS, 32'h1, 1'b0);
    rd(mac_pkg::STATUS_OFS, 32'h0, 1'b0);
    rd(8'h1c, 32'h0, 1'b1);
    end_test("registers");
    repeat (6) cmd_rw(1'b0, 1'b0, 2'h0, 4'($urandom));
    mode_register_set_cmd(2'h1, 18'h0_0104, 1'b0);
    mode_register_set_cmd(2'h2, 18'h0_0000, 1'b0);
    @(negedge clk);
    compare({41'h0, odt_enable, odt_value}, 44'h6, ALL);
    @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      m = 16'h0;
      repeat (4) m[4'($urandom)] = 1'b1;
      ctrl.issue(RF, {4'h0, m}, 20'h0, 4'($urandom), 1'b0, 1'b0);
      want_exec(mac_pkg::MAC_REFRESH, 20'h0, 4'h0, m, 1'b0, REF);
    end
    ctrl.issue(RF, 20'h0_001f, 20'h0, 4'h0, 1'b0, 1'b0);
    end_test("multibank");
    rd(mac_pkg::ERR_OFS, 32'h2, 1'b0);
    apb(1'b1, mac_pkg::ERR_OFS, 32'h2);
    mode_register_set_cmd(2'h1, 18'h0_0004, 1'b0);
    ctrl.issue(RF, 20'($urandom), 20'h0, 4'h6, 1'b0, 1'b0);
    want_exec(mac_pkg::MAC_REFRESH, 20'h0, 4'h0, 16'h0040, 1'b0, REF);
    apb(1'b1, mac_pkg::TRC_OFS, 32'h5);
    cmd_rw(1'b0, 1'b0, 2'h0, 4'h3);
    cmd_rw(1'b0, 1'b0, 2'h0, 4'h3);
    rd(mac_pkg::ERR_OFS, 32'h1, 1'b0);
    apb(1'b1, mac_pkg::ERR_OFS, 32'h1);
    repeat (8) @(posedge clk);
    cmd_rw(1'b0, 1'b0, 2'h0, 4'h3);
    rd(mac_pkg::ERR_OFS, 32'h0, 1'b0);
    end_test("single");
    mode_register_set_cmd(2'h0, 18'h0_0200, 1'b0);
    repeat (SPACING) @(posedge clk);
    rd(mac_pkg::STATUS_OFS, 32'h7, 1'b0);
    mode_register_set_cmd(2'h0, 18'h0_0200, 1'b1);
    for (int k = 0; k < 5; k++) begin
      // The wide width never gets a burst of eight.
      wide = (k > 2);
      bl = 2'(k % 3);
      apb(1'b1, mac_pkg::CTRL_OFS, {31'h0, wide});
      mode_register_set_cmd(2'h1, 18'h0_0104 | (18'(bl) << 3), 1'b1);
      repeat (4) cmd_rw(1'b1, wide, bl, 4'($urandom));
      ctrl.issue(RF, 20'h0_0009, 20'h0_0008, 4'($urandom), 1'b1, 1'b0);
      want_exec(mac_pkg::MAC_REFRESH, 20'h0, 4'h0, 16'h000b, 1'b0, REF);
    end
    mode_register_set_cmd(2'h1, 18'h0_000c, 1'b1);
    ctrl.issue(RF, 20'($urandom), 20'h0, 4'h5, 1'b1, 1'b1);
    want_exec(mac_pkg::MAC_REFRESH, 20'h0, 4'h0, 16'h0020, 1'b0, REF);
    cmd_rw(1'b1, 1'b1, mac_pkg::BL_FOUR, 4'h9);
    end_test("two-part");
    test_done();
  end
endmodule
